// ===== adc_regs_consts.svh
// offsets, field positions and reset values of the result, checksum and sync/error registers
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH

`define OFS_REG_CHECKSUM    6'h03
`define OFS_CONV_RESULT     6'h04
`define OFS_SYNC_ERR_CFG    6'h06

`define CFG_RESET           16'h0800
`define CFG_RSVD_HI         15
`define CFG_RSVD_LO         13
`define CFG_MUX_BIT         12
`define CFG_SYNC_BIT        11
`define CFG_ERR_HI          10
`define CFG_ERR_LO          9
`define CFG_LEVEL_BIT       8
`define CFG_LOW_MASK        16'h003f

`define ERR_MODE_OFF        2'h0
`define ERR_MODE_INPUT      2'h1
`define ERR_MODE_OD_OUT     2'h2
`define ERR_MODE_GP_OUT     2'h3

`define RESULT_RESET        32'h00000000
`define CHECKSUM_W          24
`define NARROW_SHIFT        8

`endif

// ===== adc_regs_pkg.sv
// types shared by the result, checksum and sync/error register logic
package adc_regs_pkg;

   // one decoded command from the serial register interface
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [5:0]  addr;
      logic [31:0] wdata;
   } reg_cmd_s;

   // channel sequencer states, gray coded along idle -> wait -> settle
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_WAIT   = 2'b01,
      SEQ_SETTLE = 2'b11
   } seq_e;

   typedef struct packed {
      logic [15:0] cfg;
      logic [31:0] result;
      logic [31:0] pend;
      logic        pend_v;
      logic        hold;
      logic        rdy_n;
      logic        sync1;
      logic        sync2;
      logic        pin_prev;
      logic        en_prev;
      logic [23:0] snap;
      logic        integ_err;
      seq_e        seq;
      logic [7:0]  cnt;
      logic [1:0]  aux;
      logic        aux_drive;
      logic [31:0] rd_data;
      logic        rd_valid;
      logic        mod_rst;
      logic        conv_start;
      logic        pin_out;
      logic        pin_oe_n;
      logic        conv_err;
   } state_s;

endpackage

// ===== adc_result_sync_error_regs.sv
// result, checksum and sync/error pin register logic of the converter's digital side
`timescale 1ns/100ps
`include "adc_regs_consts.svh"

module adc_result_sync_error_regs
   import adc_regs_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire reg_cmd_s    cmd_i,
   input  wire logic        access_end_i,
   input  wire logic        integrity_check_enable_i,
   input  wire logic        wide_word_select_i,
   input  wire logic        alternate_sync_mode_i,
   input  wire logic [23:0] user_regs_fold_i,
   input  wire logic        result_valid_i,
   input  wire logic [31:0] raw_result_i,
   input  wire logic        polarity_select_i,
   input  wire logic        channel_switch_due_i,
   input  wire logic [1:0]  next_channel_i,
   input  wire logic        multi_channel_i,
   input  wire logic [7:0]  mux_settle_cycles_i,
   input  wire logic        adc_fault_i,
   input  wire logic        crc_error_i,
   input  wire logic        sync_error_pin_i,
   output logic [31:0]      rd_data_o,
   output logic             rd_valid_o,
   output logic             result_ready_n_o,
   output logic             integrity_error_flag_o,
   output logic             converter_error_flag_o,
   output logic             modulator_reset_o,
   output logic             conversion_start_o,
   output logic             aux_io_0_o,
   output logic             aux_io_1_o,
   output logic             aux_mux_drive_o,
   output logic             sync_error_pin_o,
   output logic             sync_error_pin_oe_n_o
);

   // the two aux pins address at most four external mux inputs
   if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
      $error("CHANNELS must lie between 1 and 4");
   end

   state_s q;
   state_s d;

   // fold a 16-bit register into the 24-bit checksum lane
   function automatic logic [23:0] checksum(input logic [15:0] cfg, input logic [23:0] fold);
      checksum = {8'h00, cfg} ^ fold;
   endfunction

   // coding first, then word length, both fixed at the moment a result arrives
   function automatic logic [31:0] fmt_result(input logic [31:0] raw, input logic uni,
                                              input logic wide);
      logic [31:0] v;
      v = uni ? raw : {~raw[31], raw[30:0]};
      fmt_result = wide ? v : (v >> `NARROW_SHIFT);
   endfunction

   logic [1:0]  err_mode;
   logic        sync_en;
   logic        pin_used;
   logic        pin_lvl;
   logic        alt_act;
   logic [23:0] cs_now;
   logic        any_err;
   logic        rd_cmd;
   logic        wr_cmd;

   // decoded configuration and pin qualifiers
   always_comb begin
      err_mode = q.cfg[`CFG_ERR_HI:`CFG_ERR_LO];
      sync_en  = q.cfg[`CFG_SYNC_BIT];
      pin_used = sync_en || (err_mode != `ERR_MODE_OFF);
      pin_lvl  = pin_used ? q.sync2 : 1'b1; // idle level when ignored
      alt_act  = alternate_sync_mode_i && multi_channel_i;
      cs_now   = checksum(q.cfg, user_regs_fold_i);
      any_err  = q.conv_err || q.integ_err || crc_error_i;
      rd_cmd   = cmd_i.valid && !cmd_i.write;
      wr_cmd   = cmd_i.valid && cmd_i.write;
   end

   // next state of the whole block
   always_comb begin
      d = q;
      d.rd_valid   = 1'b0;
      d.conv_start = 1'b0;

      // pin synchroniser; only the second stage is read
      d.sync1    = sync_error_pin_i;
      d.sync2    = q.sync1;
      d.pin_prev = pin_lvl;

      // config writes; reserved top bits and the unmapped low bits are dropped
      if (wr_cmd && cmd_i.addr == `OFS_SYNC_ERR_CFG) begin
         d.cfg = cmd_i.wdata[15:0] & (16'h1f00 | `CFG_LOW_MASK);
      end

      // integrity check: snapshot on enable, flag on any change, clear on disable
      d.en_prev = integrity_check_enable_i;
      if (!integrity_check_enable_i) begin
         d.integ_err = 1'b0;
      end else if (!q.en_prev) begin
         d.snap = cs_now;
      end else if (cs_now != q.snap) begin
         d.integ_err = 1'b1;
      end

      // register reads answer one cycle after the command
      if (rd_cmd) begin
         d.rd_valid = 1'b1;
         unique case (cmd_i.addr)
            `OFS_REG_CHECKSUM: begin
               d.rd_data = integrity_check_enable_i ? {8'h00, cs_now} : 32'h00000000;
            end
            `OFS_CONV_RESULT: begin
               d.rd_data = q.result;
               d.rdy_n   = 1'b1;
               d.hold    = 1'b1;
            end
            `OFS_SYNC_ERR_CFG: begin
               d.rd_data = {16'h0000, q.cfg};
               // the error input shows the sampled pin; sync use keeps the stored bit
               if (err_mode == `ERR_MODE_INPUT) begin
                  d.rd_data[`CFG_LEVEL_BIT] = q.sync2;
               end
            end
            default: d.rd_data = 32'h00000000;
         endcase
      end

      // a result arriving during a read access waits in the pending slot
      // a result read in the same cycle keeps the hold, so nothing lands mid-access
      if (q.hold && access_end_i && !(rd_cmd && cmd_i.addr == `OFS_CONV_RESULT)) begin
         d.hold = 1'b0;
         if (q.pend_v) begin
            d.result = q.pend;
            d.pend_v = 1'b0;
            d.rdy_n  = 1'b0;
         end
      end
      if (result_valid_i) begin
         if (d.hold) begin // still held next cycle, so park the newest result
            d.pend   = fmt_result(raw_result_i, polarity_select_i, wide_word_select_i);
            d.pend_v = 1'b1;
         end else begin
            d.result = fmt_result(raw_result_i, polarity_select_i, wide_word_select_i);
            d.rdy_n  = 1'b0;
         end
      end

      // ordinary sync holds the modulator while the pin is low
      d.mod_rst = sync_en && !alt_act && !pin_lvl;

      // channel sequencing with optional mux settling and alternate sync
      unique case (q.seq)
         SEQ_IDLE: begin
            if (channel_switch_due_i) begin
               if (q.cfg[`CFG_MUX_BIT]) begin
                  d.aux = next_channel_i;
               end
               d.cnt = q.cfg[`CFG_MUX_BIT] ? mux_settle_cycles_i : 8'h00;
               d.seq = (alt_act && !pin_lvl) ? SEQ_WAIT : SEQ_SETTLE;
            end
         end
         SEQ_WAIT: begin
            if (pin_lvl && !q.pin_prev) begin
               d.seq = SEQ_SETTLE;
            end else if (!alt_act) begin
               d.seq = SEQ_SETTLE;
            end
         end
         SEQ_SETTLE: begin
            if (q.cnt == 8'h00) begin
               d.conv_start = 1'b1;
               d.seq        = SEQ_IDLE;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         default: d.seq = SEQ_IDLE;
      endcase
      d.aux_drive = q.cfg[`CFG_MUX_BIT];

      // error flag and pin drive per error mode
      d.conv_err = adc_fault_i || (err_mode == `ERR_MODE_INPUT && !q.sync2);
      unique case (err_mode)
         `ERR_MODE_OD_OUT: begin
            d.pin_out  = 1'b0;
            d.pin_oe_n = !any_err;
         end
         `ERR_MODE_GP_OUT: begin
            d.pin_out  = q.cfg[`CFG_LEVEL_BIT];
            d.pin_oe_n = 1'b0;
         end
         default: begin
            d.pin_out  = 1'b0;
            d.pin_oe_n = 1'b1;
         end
      endcase
   end

   // one register stage for the whole block
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q            <= '0;
         q.cfg        <= `CFG_RESET;
         q.result     <= `RESULT_RESET;
         q.rdy_n      <= 1'b1;
         q.sync1      <= 1'b1;
         q.sync2      <= 1'b1;
         q.pin_prev   <= 1'b1;
         q.seq        <= SEQ_IDLE;
         q.pin_oe_n   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // every output straight from the state register
   assign rd_data_o              = q.rd_data;
   assign rd_valid_o             = q.rd_valid;
   assign result_ready_n_o       = q.rdy_n;
   assign integrity_error_flag_o = q.integ_err;
   assign converter_error_flag_o = q.conv_err;
   assign modulator_reset_o      = q.mod_rst;
   assign conversion_start_o     = q.conv_start;
   assign aux_io_0_o             = q.aux[0];
   assign aux_io_1_o             = q.aux[1];
   assign aux_mux_drive_o        = q.aux_drive;
   assign sync_error_pin_o       = q.pin_out;
   assign sync_error_pin_oe_n_o  = q.pin_oe_n;

   // checksum read while disabled answers zero
   a_cksum_reads_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_cmd && cmd_i.addr == `OFS_REG_CHECKSUM && !integrity_check_enable_i
      |=> rd_valid_o && rd_data_o == 32'h00000000)
      else $error("checksum read nonzero while disabled");

   // result read raises ready and engages the hold
   a_read_rdy_high: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_cmd && cmd_i.addr == `OFS_CONV_RESULT && !result_valid_i
      |=> result_ready_n_o && q.hold)
      else $error("result read left ready low");

   // held result stays untouched by new conversions
   a_hold_result: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.hold && !access_end_i |=> $stable(q.result))
      else $error("result overwritten during read access");

   // narrow words leave the top byte clear
   a_word_len: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      result_valid_i && !q.hold && !rd_cmd && !wide_word_select_i
      |=> q.result[31:24] == 8'h00 && !result_ready_n_o)
      else $error("24-bit result has upper byte set");

   // ordinary sync low holds the modulator
   a_sync_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sync_en && !alt_act && !pin_lvl |=> modulator_reset_o)
      else $error("sync low did not hold modulator");

   // alternate sync blocks the start while the pin stays low
   a_alt_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.seq == SEQ_WAIT && alt_act && !pin_lvl |=> !conversion_start_o ##1 !conversion_start_o)
      else $error("conversion started with sync low");

   // open drain output pulls low on any error
   a_od_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      err_mode == `ERR_MODE_OD_OUT |=> !sync_error_pin_o && sync_error_pin_oe_n_o == !$past(any_err))
      else $error("open drain error pin wrong");

   // general output follows the level bit
   a_gpo_level: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      err_mode == `ERR_MODE_GP_OUT
      |=> !sync_error_pin_oe_n_o && sync_error_pin_o == $past(q.cfg[`CFG_LEVEL_BIT]))
      else $error("general output level wrong");

   // pin released when unused
   a_pin_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !pin_used |=> sync_error_pin_oe_n_o && !modulator_reset_o)
      else $error("unused pin driven or sampled");

   // register change under enabled check raises the flag
   a_integ_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      integrity_check_enable_i && q.en_prev && cs_now != q.snap |=> integrity_error_flag_o)
      else $error("integrity change not flagged");

   // enabled checksum read returns the fold of config and user registers
   a_cksum_value: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_cmd && cmd_i.addr == `OFS_REG_CHECKSUM && integrity_check_enable_i
      |=> rd_data_o == {8'h00, $past(user_regs_fold_i) ^ {8'h00, $past(q.cfg)}})
      else $error("checksum read value wrong");

   // reserved config bits never hold a one
   a_cfg_rsvd: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.cfg[`CFG_RSVD_HI:`CFG_RSVD_LO] == 3'b000 && q.cfg[7:6] == 2'b00)
      else $error("reserved config bits set");

   // low error input reaches the converter error flag
   a_err_input: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      err_mode == `ERR_MODE_INPUT && !q.sync2 |=> converter_error_flag_o)
      else $error("error input not flagged");

   // a channel switch under mux control puts its address on the aux pins
   a_mux_addr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.seq == SEQ_IDLE && channel_switch_due_i && q.cfg[`CFG_MUX_BIT]
      |=> {aux_io_1_o, aux_io_0_o} == $past(next_channel_i) && aux_mux_drive_o)
      else $error("mux address not driven");

   // the start waits until the settling count has run out
   a_settle_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      q.seq == SEQ_SETTLE |=> conversion_start_o == ($past(q.cnt) == 8'h00))
      else $error("start not aligned to settling count");

   // a result read answers with the held result word
   a_result_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_cmd && cmd_i.addr == `OFS_CONV_RESULT |=> rd_valid_o && rd_data_o == $past(q.result))
      else $error("result read data wrong");

   // dropping the enable clears the integrity error
   a_integ_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !integrity_check_enable_i |=> !integrity_error_flag_o)
      else $error("integrity error kept while disabled");

endmodule

// ===== adc_host_model.sv
// host controller model: issues single-word register commands and ends result reads
`timescale 1ns/100ps
module adc_host_model
   import adc_regs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rd_valid_i,
   input  wire logic [31:0] rd_data_i,
   output reg_cmd_s         cmd_o,
   output logic             access_end_o
);
   // idle bus from time zero so no command is seen during reset
   initial begin
      cmd_o = '0;
      access_end_o = 1'b0;
   end

   // one command per call; reserved config bits go out as the caller gives them
   task automatic xfer(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic ok);
      int k;
      rdata = '0;
      ok = wr;
      @(negedge clock_i);
      cmd_o = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
      @(negedge clock_i);
      cmd_o.valid = 1'b0;
      // read valid stands one cycle only, so look at every falling edge
      for (k = 0; k < 4 && !ok; k++) begin
         if (rd_valid_i === 1'b1) begin
            rdata = rd_data_i;
            ok = 1'b1;
         end else begin
            @(negedge clock_i);
         end
      end
   endtask

   // closes a result read so held results may land
   task automatic end_access();
      @(negedge clock_i);
      access_end_o = 1'b1;
      @(negedge clock_i);
      access_end_o = 1'b0;
   endtask
endmodule

// ===== adc_result_sync_error_regs_tb.sv
// self-checking testbench of the result, checksum and sync/error register logic
`timescale 1ns/100ps
module adc_result_sync_error_regs_tb;
   import adc_regs_pkg::*;
   logic        clk, rst_n, acc_end, ice, wws, asm, rv, pol, swd, multi, fault, crc, ext_low;
   logic        rdv, rdy_n, ierr, cerr, mrst, cstart, aux0, aux1, auxd, pin_o, pin_oe_n;
   logic [23:0] fold;
   logic [31:0] raw, rdd, d, old;
   logic [7:0]  settle;
   logic [1:0]  nch;
   reg_cmd_s    cmd;
   wire         pin;
   int          err_count, n_tests, k, first;
   logic [31:0] exp_q[$];

   // pull-up on the pin; the bench pulls it low in the far side's place
   assign pin = ext_low ? 1'b0 : (pin_oe_n ? 1'b1 : pin_o);

   adc_host_model host_u (.clock_i(clk), .rd_valid_i(rdv), .rd_data_i(rdd), .cmd_o(cmd),
                          .access_end_o(acc_end));

   adc_result_sync_error_regs #(.CHANNELS(4)) dut_u (
      .clock_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .access_end_i(acc_end),
      .integrity_check_enable_i(ice), .wide_word_select_i(wws), .alternate_sync_mode_i(asm),
      .user_regs_fold_i(fold), .result_valid_i(rv), .raw_result_i(raw),
      .polarity_select_i(pol), .channel_switch_due_i(swd), .next_channel_i(nch),
      .multi_channel_i(multi), .mux_settle_cycles_i(settle), .adc_fault_i(fault),
      .crc_error_i(crc), .sync_error_pin_i(pin), .rd_data_o(rdd), .rd_valid_o(rdv),
      .result_ready_n_o(rdy_n), .integrity_error_flag_o(ierr),
      .converter_error_flag_o(cerr), .modulator_reset_o(mrst), .conversion_start_o(cstart),
      .aux_io_0_o(aux0), .aux_io_1_o(aux1), .aux_mux_drive_o(auxd),
      .sync_error_pin_o(pin_o), .sync_error_pin_oe_n_o(pin_oe_n));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // a read that never answers yields unknown data, which fails its comparison
   task automatic rd(input logic [5:0] a);
      logic ok;
      host_u.xfer(1'b0, a, '0, d, ok);
      if (!ok) d = 'x;
   endtask

   task automatic wr(input logic [15:0] v);
      logic ok;
      host_u.xfer(1'b1, 6'h06, {16'h0, v}, d, ok);
      repeat (5) @(negedge clk);
   endtask

   // model of the result path: coding first, then word length
   task automatic new_result();
      raw = $urandom;
      d = pol ? raw : raw ^ 32'h80000000;
      exp_q.push_back(wws ? d : d >> 8);
      @(negedge clk) rv = 1'b1;
      @(negedge clk) rv = 1'b0;
      @(negedge clk);
   endtask

   // pulses a channel switch and counts start pulses over n falling edges
   task automatic starts(input int n);
      @(negedge clk) swd = 1'b1;
      @(negedge clk) swd = 1'b0;
      k = 0;
      first = 0;
      for (int i = 1; i <= n; i++) begin
         if (cstart === 1'b1) begin
            k++;
            if (first == 0) first = i;
         end
         @(negedge clk);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #200000;
      err_count++;
      $display("watchdog expired");
      final_report();
   end

   initial begin
      {rst_n, ice, rv, pol, swd, asm, multi, fault, crc, ext_low} = '0;
      {wws, fold, raw, nch, settle} = {1'b1, 24'h0, 32'h0, 2'h0, 8'h0};
      void'($urandom(32'h550b));
      repeat (6) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      rd(6'h06);
      check(d, 32'h0800);
      rd(6'h03);
      check(d, 32'h0);
      $display("test reset done");
      // reserved bits dropped; mode 11 drives the stored level
      wr(16'hffff);
      rd(6'h06);
      check(d, 32'h1f3f);
      check({pin_oe_n, pin_o}, 2'b01);
      wr(16'h1e3f);
      check({pin_oe_n, pin}, 2'b00);
      $display("test config done");
      fold = 24'($urandom);
      ice = 1'b1;
      repeat (3) @(negedge clk);
      rd(6'h03);
      check(d, {8'h0, fold ^ 24'h001e3f});
      check(ierr, 1'b0);
      fold = fold ^ 24'h000100;
      repeat (4) @(negedge clk);
      check(ierr, 1'b1);
      ice = 1'b0;
      repeat (3) @(negedge clk);
      check(ierr, 1'b0);
      $display("test checksum done");
      for (int i = 0; i < 4; i++) begin
         {pol, wws} = i[1:0];
         new_result();
         check(rdy_n, 1'b0);
         rd(6'h04);
         old = exp_q.pop_front();
         check(d, old);
         check(rdy_n, 1'b1);
         wws = ~wws;
         rd(6'h04);
         check(d, old);
         host_u.end_access();
      end
      // result arriving during a read access waits for the access end
      rd(6'h04);
      new_result();
      rd(6'h04);
      check(d, old);
      host_u.end_access();
      repeat (2) @(negedge clk);
      check(rdy_n, 1'b0);
      rd(6'h04);
      check(d, exp_q.pop_front());
      host_u.end_access();
      $display("test result done");
      wr(16'h0800);
      ext_low = 1'b1;
      repeat (5) @(negedge clk);
      check(mrst, 1'b1);
      ext_low = 1'b0;
      repeat (5) @(negedge clk);
      check(mrst, 1'b0);
      ext_low = 1'b1;
      wr(16'h0200);
      check(cerr, 1'b1);
      rd(6'h06);
      check(d, 32'h0200);
      ext_low = 1'b0;
      repeat (5) @(negedge clk);
      check(cerr, 1'b0);
      rd(6'h06);
      check(d, 32'h0300);
      wr(16'h0400);
      check(pin_oe_n, 1'b1);
      fault = 1'b1;
      repeat (3) @(negedge clk);
      check({pin_oe_n, pin}, 2'b00);
      fault = 1'b0;
      crc = 1'b1;
      repeat (3) @(negedge clk);
      check(pin_oe_n, 1'b0);
      crc = 1'b0;
      repeat (3) @(negedge clk);
      check(pin_oe_n, 1'b1);
      ext_low = 1'b1;
      wr(16'h0000);
      check({mrst, cerr, pin_oe_n}, 3'b001);
      $display("test pin done");
      // alternate sync with several channels: low pin blocks the start
      {asm, multi} = 2'b11;
      wr(16'h0800);
      starts(6);
      check(k, 0);
      ext_low = 1'b0;
      starts(8);
      check(k, 1);
      {asm, multi} = 2'b10;
      ext_low = 1'b1;
      repeat (5) @(negedge clk);
      check(mrst, 1'b1);
      ext_low = 1'b0;
      wr(16'h1000);
      nch = 2'($urandom);
      settle = 8'($urandom % 6); // settling wait of 0 to 5 cycles after the mux switch
      starts(10);
      check(first, 2 + settle);
      check({auxd, aux1, aux0}, {1'b1, nch});
      $display("test sequencer done");
      final_report();
   end
endmodule
